/* common/ssp_pkg.sv */
// constants, field layouts and state types for the burst sram port
// assumes one 20 MHz core clock and an async active-high reset
package ssp_pkg;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int LANES     = 4;                 // byte lanes
  localparam int LANE_W    = 9;                 // bits per lane
  localparam int DATA_W    = LANES * LANE_W;    // 36-bit word
  localparam int LOW_W     = 2;                 // burst counter width
  localparam int HI_W      = 4;                 // upper address width
  localparam int ADDR_W    = HI_W + LOW_W;      // word address width
  localparam int DEPTH     = 1 << ADDR_W;       // words held in flops

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam int          AXI_AW       = 8;     // byte address width
  localparam logic [7:0]  CTRL_OFS     = 8'h00; // control register
  localparam logic [7:0]  STAT_OFS     = 8'h04; // status register
  localparam int          CTRL_WBLK    = 0;     // write block bit
  localparam logic        CTRL_RST     = 1'h0;  // control reset value
  localparam int          ST_SLEEP     = 0;     // sleep active
  localparam int          ST_PIPE      = 1;     // pipelined mode
  localparam int          ST_DRIVE     = 2;     // output data valid
  localparam int          ST_GATE      = 3;     // clock gate open
  localparam int          ST_LOW       = 4;     // counter bits [5:4]
  localparam int          ST_KIND      = 6;     // burst kind [7:6]
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // kind of burst now under way
  typedef enum logic [1:0] {
    KIND_IDLE  = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10
  } ssp_kind_t;

  // one stage of the late-write pipe
  typedef struct packed {
    logic                 vld;
    logic [ADDR_W-1:0]    addr;
    logic [LANES-1:0]     strb_n;
  } ssp_wstage_t;

  // burst counter state
  typedef struct packed {
    logic [LOW_W-1:0]     base;
    logic [LOW_W-1:0]     beat;
  } ssp_ctr_t;

  // register bus slave state
  typedef struct packed {
    logic                 aw_got;
    logic                 w_got;
    logic [AXI_AW-1:0]    awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 wblk;
  } ssp_axi_t;

  // core state of the ram port
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    ssp_kind_t            kind;
    logic [HI_W-1:0]      addr_hi;
    ssp_wstage_t          w1;
    ssp_wstage_t          w2;
    logic                 s1_rd;
    logic [DATA_W-1:0]    s1_data;
    logic                 drv;
    logic [DATA_W-1:0]    dout;
  } ssp_core_t;

endpackage

/* src/ssp_burst_ctr.sv */
// two-bit burst address counter with linear or interleaved order
// assumes load and step come qualified by the active clock edge
`timescale 1ns/1ns
module ssp_burst_ctr
  import ssp_pkg::*;
(
  input  wire logic             clk_in,        // core clock
  input  wire logic             reset_in,      // async reset, high
  input  wire logic             load_in,       // take new start bits
  input  wire logic             step_in,       // advance one beat
  input  wire logic [LOW_W-1:0] start_in,      // preload value
  input  wire logic             order_n_in,    // low: linear order
  output logic      [LOW_W-1:0] op_low_out,    // low bits used now
  output logic      [LOW_W-1:0] cur_low_out    // low bits held
);

  ssp_ctr_t st;
  ssp_ctr_t st_nxt;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  function automatic logic [LOW_W-1:0] seq(input logic [LOW_W-1:0] b,
                                           input logic [LOW_W-1:0] n,
                                           input logic             ord_n);
    // wrap inside the four-word group
    seq = ord_n ? (b ^ n) : LOW_W'(b + n);
  endfunction

  // next state and the address used on this edge
  always_comb begin
    st_nxt = st;
    if (load_in) begin
      st_nxt.base = start_in;
      st_nxt.beat = '0;
    end else if (step_in) begin
      st_nxt.beat = LOW_W'(st.beat + 1'b1);
    end
    op_low_out  = seq(st_nxt.base, st_nxt.beat, order_n_in);
    cur_low_out = seq(st.base, st.beat, order_n_in);
  end

  // state register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

endmodule

/* src/ssp_sram_port.sv */
// synchronous burst static ram with late writes and no turnaround
// assumes pins sampled on CORE_CLK_IN; drive enable and sleep act
// on the data drivers without the clock; registers over axi4-lite
`timescale 1ns/1ns

// How it works
// - inputs except drive enable and sleep sampled only at rising clock edge
// - drive enable high turns drivers off immediately
// - sleep request high powers down, ignores clock
// - writes commit internally from the clock edge
// - pipelined read data leaves register next edge
// - mode pin low flow-through, high pipelined
// - read latency 3-1-1-1 pipelined, 2-1-1-1 flow
// - data split into four nine-bit lanes
// - each lane strobe writes only its lane
// - selected only when all three selects active
// - clock gate high blocks edges from logic
// - step/load pin drives burst address counter
// - low address bits preload counter at start
// - order pin low linear, high interleaved
// - read and write follow without idle cycle
// - write data two or one edges later
// - flow-through data appears right after address
// - step pin high advances, low loads address
// - gate high inserts wait, state unchanged
module ssp_sram_port
  import ssp_pkg::*;
(
  input  wire logic              CORE_CLK_IN,                  // core clock, 20 MHz
  input  wire logic              RESET_IN,                     // async reset, high
  input  wire logic [HI_W-1:0]   ADDR_HIGH_IN,                 // upper word address
  input  wire logic [LOW_W-1:0]  BURST_START_LOW_BITS_IN,      // counter preload
  input  wire logic              WRITE_N_IN,                   // write command, low
  input  wire logic              LANE_ONE_WRITE_N_IN,          // lane 1 strobe, low
  input  wire logic              LANE_TWO_WRITE_N_IN,          // lane 2 strobe, low
  input  wire logic              LANE_THREE_WRITE_N_IN,        // lane 3 strobe, low
  input  wire logic              LANE_FOUR_WRITE_N_IN,         // lane 4 strobe, low
  input  wire logic              SELECT_FIRST_N_IN,            // select 1, low
  input  wire logic              SELECT_SECOND_HIGH_IN,        // select 2, high
  input  wire logic              SELECT_THIRD_N_IN,            // select 3, low
  input  wire logic              COUNTER_STEP_OR_LOAD_IN,      // high step, low load
  input  wire logic              CLOCK_GATE_N_IN,              // edges pass when low
  input  wire logic              OUTPUT_DRIVE_N_IN,            // drivers on when low
  input  wire logic              SLEEP_REQUEST_IN,             // power down, high
  input  wire logic              UNREGISTERED_OUTPUT_SELECT_N_IN, // low flow-through
  input  wire logic              SEQUENTIAL_ORDER_SELECT_N_IN, // low linear order
  input  wire logic [LANE_W-1:0] LANE_ONE_IO_IN,               // lane 1 pin level
  output logic      [LANE_W-1:0] LANE_ONE_IO_OUT,              // lane 1 drive value
  output logic                   LANE_ONE_IO_OE_OUT,           // lane 1 driving
  input  wire logic [LANE_W-1:0] LANE_TWO_IO_IN,               // lane 2 pin level
  output logic      [LANE_W-1:0] LANE_TWO_IO_OUT,              // lane 2 drive value
  output logic                   LANE_TWO_IO_OE_OUT,           // lane 2 driving
  input  wire logic [LANE_W-1:0] LANE_THREE_IO_IN,             // lane 3 pin level
  output logic      [LANE_W-1:0] LANE_THREE_IO_OUT,            // lane 3 drive value
  output logic                   LANE_THREE_IO_OE_OUT,         // lane 3 driving
  input  wire logic [LANE_W-1:0] LANE_FOUR_IO_IN,              // lane 4 pin level
  output logic      [LANE_W-1:0] LANE_FOUR_IO_OUT,             // lane 4 drive value
  output logic                   LANE_FOUR_IO_OE_OUT,          // lane 4 driving
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,                 // write address
  input  wire logic              S_AXI_AWVALID,                // write address valid
  output logic                   S_AXI_AWREADY,                // write address ready
  input  wire logic [31:0]       S_AXI_WDATA,                  // write data
  input  wire logic [3:0]        S_AXI_WSTRB,                  // byte enables
  input  wire logic              S_AXI_WVALID,                 // write data valid
  output logic                   S_AXI_WREADY,                 // write data ready
  output logic      [1:0]        S_AXI_BRESP,                  // write response
  output logic                   S_AXI_BVALID,                 // response valid
  input  wire logic              S_AXI_BREADY,                 // response ready
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,                 // read address
  input  wire logic              S_AXI_ARVALID,                // read address valid
  output logic                   S_AXI_ARREADY,                // read address ready
  output logic      [31:0]       S_AXI_RDATA,                  // read data
  output logic      [1:0]        S_AXI_RRESP,                  // read response
  output logic                   S_AXI_RVALID,                 // read data valid
  input  wire logic              S_AXI_RREADY                  // read data ready
);

  ssp_core_t         st;
  ssp_core_t         st_nxt;
  ssp_axi_t          ax;
  ssp_axi_t          ax_nxt;
  logic              act;
  logic              sel;
  logic              pipe;
  logic              load;
  logic              step;
  ssp_kind_t         kind_now;
  logic              is_read;
  logic              is_write;
  logic [LOW_W-1:0]  op_low;
  logic [LOW_W-1:0]  cur_low;
  logic [ADDR_W-1:0] op_addr;
  logic [LANES-1:0]  strb_n;
  logic [DATA_W-1:0] din;
  logic [DATA_W-1:0] rd_word;
  ssp_wstage_t       commit;
  logic              oe;
  logic [31:0]       stat_word;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // an edge counts only with the gate open and no sleep request
  assign act  = !CLOCK_GATE_N_IN && !SLEEP_REQUEST_IN;
  assign sel  = !SELECT_FIRST_N_IN && SELECT_SECOND_HIGH_IN
                && !SELECT_THIRD_N_IN;
  assign pipe = UNREGISTERED_OUTPUT_SELECT_N_IN;
  assign load = act && !COUNTER_STEP_OR_LOAD_IN;
  assign step = act && COUNTER_STEP_OR_LOAD_IN;
  assign strb_n = {LANE_FOUR_WRITE_N_IN, LANE_THREE_WRITE_N_IN,
                   LANE_TWO_WRITE_N_IN, LANE_ONE_WRITE_N_IN};
  assign din  = {LANE_FOUR_IO_IN, LANE_THREE_IO_IN, LANE_TWO_IO_IN, LANE_ONE_IO_IN};

  // new burst takes its kind from the pins, continue keeps it
  always_comb begin
    if (!COUNTER_STEP_OR_LOAD_IN) begin
      if (!sel) begin
        kind_now = KIND_IDLE;
      end else if (WRITE_N_IN) begin
        kind_now = KIND_READ;
      end else begin
        kind_now = KIND_WRITE;
      end
    end else begin
      kind_now = st.kind;
    end
  end

  assign is_read  = act && (kind_now == KIND_READ);
  assign is_write = act && (kind_now == KIND_WRITE);

  // burst counter supplies the low address bits
  ssp_burst_ctr u_ctr (
    .clk_in      (CORE_CLK_IN),
    .reset_in    (RESET_IN),
    .load_in     (load),
    .step_in     (step),
    .start_in    (BURST_START_LOW_BITS_IN),
    .order_n_in  (SEQUENTIAL_ORDER_SELECT_N_IN),
    .op_low_out  (op_low),
    .cur_low_out (cur_low)
  );

  assign op_addr = {(load ? ADDR_HIGH_IN : st.addr_hi), op_low};
  assign rd_word = st.mem[op_addr];
  // late write leaves from the stage that matches the mode
  assign commit  = pipe ? st.w2 : st.w1;

  // ---------------------------------------------------------------
  // core next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st;
    if (act) begin
      st_nxt.kind = kind_now;
      if (load) begin
        st_nxt.addr_hi = ADDR_HIGH_IN;
      end
      // self-timed write of the enabled lanes only
      if (commit.vld && !ax.wblk) begin
        for (int l = 0; l < LANES; l++) begin
          if (!commit.strb_n[l]) begin
            st_nxt.mem[commit.addr][l*LANE_W +: LANE_W] =
              din[l*LANE_W +: LANE_W];
          end
        end
      end
      // write pipe: command now, data one or two edges later
      st_nxt.w1.vld    = is_write;
      st_nxt.w1.addr   = op_addr;
      st_nxt.w1.strb_n = strb_n;
      st_nxt.w2        = pipe ? st.w1 : '0;
      // read path: register stage in pipelined mode only
      st_nxt.s1_rd   = is_read && pipe;
      st_nxt.s1_data = rd_word;
      if (pipe) begin
        st_nxt.drv = st.s1_rd;
        if (st.s1_rd) begin
          st_nxt.dout = st.s1_data;
        end
      end else begin
        st_nxt.drv = is_read;
        if (is_read) begin
          st_nxt.dout = rd_word;
        end
      end
    end
  end

  // core state register; whole array clears at reset
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st <= '0;
    end else begin
      st <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // data pins
  // ---------------------------------------------------------------
  // drive enable and sleep cut the drivers without the clock
  assign oe = st.drv && !OUTPUT_DRIVE_N_IN && !SLEEP_REQUEST_IN;
  assign LANE_ONE_IO_OUT      = st.dout[0*LANE_W +: LANE_W];
  assign LANE_TWO_IO_OUT      = st.dout[1*LANE_W +: LANE_W];
  assign LANE_THREE_IO_OUT    = st.dout[2*LANE_W +: LANE_W];
  assign LANE_FOUR_IO_OUT     = st.dout[3*LANE_W +: LANE_W];
  assign LANE_ONE_IO_OE_OUT   = oe;
  assign LANE_TWO_IO_OE_OUT   = oe;
  assign LANE_THREE_IO_OE_OUT = oe;
  assign LANE_FOUR_IO_OE_OUT  = oe;

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  always_comb begin
    stat_word                        = '0;
    stat_word[ST_SLEEP]              = SLEEP_REQUEST_IN;
    stat_word[ST_PIPE]               = pipe;
    stat_word[ST_DRIVE]              = st.drv;
    stat_word[ST_GATE]               = !CLOCK_GATE_N_IN;
    stat_word[ST_LOW +: LOW_W]       = cur_low;
    stat_word[ST_KIND +: 2]          = st.kind;
  end

  assign S_AXI_AWREADY = !ax.aw_got && !ax.bvalid;
  assign S_AXI_WREADY  = !ax.w_got && !ax.bvalid;
  assign S_AXI_ARREADY = !ax.rvalid;
  assign S_AXI_BVALID  = ax.bvalid;
  assign S_AXI_BRESP   = ax.bresp;
  assign S_AXI_RVALID  = ax.rvalid;
  assign S_AXI_RRESP   = ax.rresp;
  assign S_AXI_RDATA   = ax.rdata;

  // take address and data in either order, answer after both
  always_comb begin
    ax_nxt = ax;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      ax_nxt.aw_got = 1'b1;
      ax_nxt.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      ax_nxt.w_got = 1'b1;
      ax_nxt.wdata = S_AXI_WDATA;
      ax_nxt.wstrb = S_AXI_WSTRB;
    end
    if (ax.aw_got && ax.w_got) begin
      ax_nxt.aw_got = 1'b0;
      ax_nxt.w_got  = 1'b0;
      ax_nxt.bvalid = 1'b1;
      if (ax.awaddr == CTRL_OFS) begin
        ax_nxt.bresp = RESP_OKAY;
        if (ax.wstrb[0]) begin
          ax_nxt.wblk = ax.wdata[CTRL_WBLK];
        end
      end else if (ax.awaddr == STAT_OFS) begin
        ax_nxt.bresp = RESP_OKAY;
      end else begin
        ax_nxt.bresp = RESP_SLVERR;
      end
    end
    if (ax.bvalid && S_AXI_BREADY) begin
      ax_nxt.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      ax_nxt.rvalid = 1'b1;
      ax_nxt.rresp  = RESP_OKAY;
      if (S_AXI_ARADDR == CTRL_OFS) begin
        ax_nxt.rdata = {31'h0, ax.wblk};
      end else if (S_AXI_ARADDR == STAT_OFS) begin
        ax_nxt.rdata = stat_word;
      end else begin
        ax_nxt.rdata = 32'h0;
        ax_nxt.rresp = RESP_SLVERR;
      end
    end else if (ax.rvalid && S_AXI_RREADY) begin
      ax_nxt.rvalid = 1'b0;
    end
  end

  // bus slave state register
  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ax      <= '0;
      ax.wblk <= CTRL_RST;
    end else begin
      ax <= ax_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  a_drive_off_async: assert property (OUTPUT_DRIVE_N_IN |-> !LANE_ONE_IO_OE_OUT)
    else $error("drivers on while drive enable high");
  a_sleep_drivers_off: assert property (SLEEP_REQUEST_IN |-> !oe ##1 $stable(st.kind))
    else $error("activity during sleep");
  a_flow_read_lat: assert property (is_read && !pipe |=> st.drv
                                    && (oe == (!OUTPUT_DRIVE_N_IN && !SLEEP_REQUEST_IN)))
    else $error("flow read data not driven after one edge");
  a_pipe_read_lat: assert property (is_read && pipe ##1 act |=> st.drv)
    else $error("pipelined read data not driven at second edge");
  a_write_no_drive: assert property (is_write && !pipe |=> !st.drv)
    else $error("drivers on after write cycle");
  a_gate_holds: assert property (!act |=> $stable(st.addr_hi) && $stable(st.dout)
                                 && $stable(cur_low))
    else $error("state changed during gated edge");
  a_deselect_off: assert property (load && !sel |=> (st.kind == KIND_IDLE && (pipe || !st.drv))
                                   and (act && pipe |=> !st.drv))
    else $error("deselect did not stop driving");
  a_wr_pipe_stage: assert property (is_write && pipe ##1 act |=> st.w2.vld
                                    && st.w2.addr == $past(op_addr, 2))
    else $error("write pipe stage lost");
  a_counter_load: assert property (load |=> cur_low == $past(BURST_START_LOW_BITS_IN))
    else $error("counter not preloaded");

endmodule

/* test/ssp_ctrl_model.sv */
// controller-side model of the burst ram pins, with late write data
// assumes put is called just after a rising edge, once per cycle
`timescale 1ns/1ns
module ssp_ctrl_model
  import ssp_pkg::*;
(
  input  wire logic              clk_in,     // core clock
  input  wire logic              hold_in,    // gate or sleep on
  input  wire logic              pipe_in,    // high: pipelined
  input  wire logic [DATA_W-1:0] ram_in,     // ram drive values
  input  wire logic [LANES-1:0]  ram_oe_in,  // ram lanes driving
  output logic      [ADDR_W-1:0] addr_out,   // word address
  output logic                   wr_n_out,   // write command, low
  output logic      [LANES-1:0]  strb_n_out, // lane strobes, low
  output logic      [2:0]        sel_out,    // selects, first..third
  output logic                   step_out,   // high step, low load
  output logic      [DATA_W-1:0] bus_out     // resolved lane wires
);
  logic [DATA_W:0]   cur_r = '0, p1_r = '0, p2_r = '0, drv; // valid, data
  logic [DATA_W-1:0] last_r = '0;

  // pins change only just after an edge
  task automatic put(input logic [ADDR_W-1:0] a, input logic wn, input logic [3:0] sn,
                     input logic [2:0] s, input logic st, input logic [DATA_W:0] wd);
    addr_out <= a;
    wr_n_out <= wn;
    strb_n_out <= sn;
    sel_out <= s;
    step_out <= st;
    cur_r <= wd;
  endtask

  initial put('0, 1'b1, 4'hf, 3'b110, 1'b0, '0);

  // late write data steps only on edges that reach the ram
  always @(posedge clk_in) begin
    last_r <= bus_out;
    if (!hold_in) begin
      p1_r <= cur_r;
      p2_r <= p1_r;
    end
  end
  assign drv = pipe_in ? p2_r : p1_r;

  // wire level: ram, else model, else a level that keeps changing
  always_comb
    for (int i = 0; i < LANES; i++)
      bus_out[i*LANE_W +: LANE_W] = ram_oe_in[i] ? ram_in[i*LANE_W +: LANE_W] :
        drv[DATA_W] ? drv[i*LANE_W +: LANE_W] : ~last_r[i*LANE_W +: LANE_W];
endmodule

/* test/ssp_sram_port_tb_top.sv */
// bench for the burst ram port: reference model, pin model, axi master
// assumes ssp_ctrl_model drives the ram pins and resolves the lanes
`timescale 1ns/1ns
module ssp_sram_port_tb_top
  import ssp_pkg::*;
  ;
  logic              clk = 0, rst = 1, pipe = 0, ord = 0, gate_n = 0, sleep = 0, odn = 0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, blk = 0;
  logic              awready, wready, bvalid, arready, rvalid, wr_n, step;
  logic [7:0]        awaddr = 0, araddr = 0;
  logic [31:0]       wdata = 0, rdata, d;
  logic [1:0]        bresp, rresp, r, base, beat;
  logic [ADDR_W-1:0] addr, a;
  logic [LANES-1:0]  strb_n;
  wire  [LANES-1:0]  oe;
  logic [2:0]        sel;
  logic [HI_W-1:0]   hi;
  logic [DATA_W-1:0] bus, mm [DEPTH];
  wire  [DATA_W-1:0] ram;
  logic [DATA_W:0]   en = 0, e1 = 0, e2 = 0, ev;
  int                kind, mismatches = 0, comparisons = 0;

  initial forever #25 clk = ~clk;

  ssp_sram_port dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .ADDR_HIGH_IN(addr[5:2]),
    .BURST_START_LOW_BITS_IN(addr[1:0]), .WRITE_N_IN(wr_n), .LANE_ONE_WRITE_N_IN(strb_n[0]),
    .LANE_TWO_WRITE_N_IN(strb_n[1]), .LANE_THREE_WRITE_N_IN(strb_n[2]),
    .LANE_FOUR_WRITE_N_IN(strb_n[3]), .SELECT_FIRST_N_IN(sel[2]), .SELECT_SECOND_HIGH_IN(sel[1]),
    .SELECT_THIRD_N_IN(sel[0]), .COUNTER_STEP_OR_LOAD_IN(step), .CLOCK_GATE_N_IN(gate_n),
    .OUTPUT_DRIVE_N_IN(odn), .SLEEP_REQUEST_IN(sleep), .UNREGISTERED_OUTPUT_SELECT_N_IN(pipe),
    .SEQUENTIAL_ORDER_SELECT_N_IN(ord), .LANE_ONE_IO_IN(bus[8:0]), .LANE_ONE_IO_OUT(ram[8:0]),
    .LANE_ONE_IO_OE_OUT(oe[0]), .LANE_TWO_IO_IN(bus[17:9]), .LANE_TWO_IO_OUT(ram[17:9]),
    .LANE_TWO_IO_OE_OUT(oe[1]), .LANE_THREE_IO_IN(bus[26:18]), .LANE_THREE_IO_OUT(ram[26:18]),
    .LANE_THREE_IO_OE_OUT(oe[2]), .LANE_FOUR_IO_IN(bus[35:27]), .LANE_FOUR_IO_OUT(ram[35:27]),
    .LANE_FOUR_IO_OE_OUT(oe[3]), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  ssp_ctrl_model ctl (.clk_in(clk), .hold_in(gate_n | sleep), .pipe_in(pipe), .ram_in(ram),
    .ram_oe_in(oe), .addr_out(addr), .wr_n_out(wr_n), .strb_n_out(strb_n), .sel_out(sel),
    .step_out(step), .bus_out(bus));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] s, input logic [63:0] x);
    comparisons++;
    if (s !== x) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one ram cycle: reference update, then pins for the next edge
  task automatic acc(input logic ld, input logic wr, input logic [2:0] s,
                     input logic [ADDR_W-1:0] ad, input logic [3:0] sn, input logic [1:0] g);
    logic [DATA_W-1:0] wd;
    logic [ADDR_W-1:0] ea;
    wd = DATA_W'({$urandom, $urandom});
    if (g == 0) begin
      if (ld) begin
        hi = ad[ADDR_W-1:LOW_W];
        base = ad[LOW_W-1:0];
        beat = 0;
        kind = (s == 3'b010) ? (wr ? 2 : 1) : 0;
      end else beat = beat + 1;
    end
    ea = {hi, ord ? base ^ beat : base + beat};
    for (int i = 0; i < LANES; i++)
      if (g == 0 && kind == 2 && !blk && !sn[i]) mm[ea][i*LANE_W +: LANE_W] = wd[i*LANE_W +: LANE_W];
    en <= {g == 0 && kind == 1, mm[ea]};
    gate_n <= g[0];
    sleep <= g[1];
    ctl.put(ad, !wr, sn, s, !ld, {g == 0 && kind == 2, wd});
    @(posedge clk);
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] dv, output logic [1:0] rs);
    awaddr <= ad;
    wdata <= dv;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (awvalid && !awready || wvalid && !wready);
    do @(posedge clk); while (bvalid !== 1);
    rs = bresp;
    bready <= 0;
  endtask

  task automatic axr(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rs);
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1);
    dv = rdata;
    rs = rresp;
    rready <= 0;
    @(posedge clk); // one edge between back-to-back reads
  endtask

  // expected read results move on edges that reach the ram
  always @(posedge clk or posedge rst)
    if (rst) begin
      e1 <= 0;
      e2 <= 0;
    end else if (!gate_n && !sleep) begin
      e1 <= en;
      e2 <= e1;
    end

  // lane drivers compared once every cycle, data only on cycles the ram should drive
  always @(negedge clk) begin
    ev = pipe ? e2 : e1;
    check(oe, {LANES{ev[DATA_W] && !odn && !sleep}});
    if (ev[DATA_W] && !odn && !sleep) check(bus, ev[DATA_W-1:0]);
  end

  // ----------------------------------------------------------------
  // test sequence, every mode and order
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'haf43));
    for (int m = 0; m < 4; m++) begin
      rst <= 1;
      pipe <= m[0];
      ord <= m[1];
      repeat (5) @(posedge clk);
      rst <= 0;
      foreach (mm[i]) mm[i] = 0;
      kind = 0;
      a = ADDR_W'($urandom);
      @(posedge clk);
      acc(1, 1, 3'b010, a, 4'h0, 0);
      repeat (3) acc(0, 1, 3'b010, a, 4'h0, 0);
      acc(1, 0, 3'b110 >> m, a, 4'hf, 0);
      acc(1, 0, 3'b010, a, 4'hf, 0);
      repeat (2) acc(0, 0, 3'b010, a, 4'hf, 1);
      repeat (3) acc(0, 0, 3'b010, a, 4'hf, 0);
      acc(1, 1, 3'b010, a ^ 6'h20, 4'h0, 0);
      acc(1, 0, 3'b010, a ^ 6'h01, 4'hf, 0);
      for (int i = 0; i < LANES; i++) acc(1, 1, 3'b010, a, ~(4'h1 << i), 0);
      acc(1, 1, 3'b010, a, 4'hf, 0);
      repeat (2) acc(1, 0, 3'b000, a, 4'hf, 0);
      odn <= 1;
      repeat (2) acc(1, 0, 3'b010, a, 4'hf, 0);
      odn <= 0;
      acc(1, 1, 3'b010, a, 4'h0, 2);
      acc(1, 0, 3'b010, a, 4'hf, 0);
      repeat (2) acc(1, 0, 3'b000, a, 4'hf, 0);
      axr(STAT_OFS, d, r);
      check({r, d[ST_PIPE]}, {RESP_OKAY, m[0]});
      axr(8'h08, d, r);
      check({r, d}, {RESP_SLVERR, 32'h0});
      axw(CTRL_OFS, 32'h1, r);
      check(r, RESP_OKAY);
      axr(CTRL_OFS, d, r);
      check({r, d}, {RESP_OKAY, 32'h1});
      blk = 1;
      acc(1, 1, 3'b010, a, 4'h0, 0);
      repeat (3) acc(1, 0, 3'b000, a, 4'hf, 0);
      axw(CTRL_OFS, 32'h0, r);
      blk = 0;
      acc(1, 0, 3'b010, a, 4'hf, 0);
      repeat (2) acc(1, 0, 3'b000, a, 4'hf, 0);
      $display("pass %0d done", m);
    end
    conclude;
  end

  // watchdog well beyond the few hundred cycles the passes take
  initial begin
    #(50 * 4000);
    mismatches++;
    conclude;
  end
endmodule
